// [design/rap_pin_sync.v]
`timescale 1ns/1ps
`default_nettype none

// two-stage synchroniser per pin, then polarity applied to the clean level
module rap_pin_sync #(
    parameter NPINS = 8
) (
    // clock and reset
    input  wire             clk,
    input  wire             resetn,
    // raw pins and polarity (1 = active low)
    input  wire [NPINS-1:0] pin_raw,
    input  wire [NPINS-1:0] pol_low,
    // asserted level per pin
    output wire [NPINS-1:0] pin_active
);

    reg [NPINS-1:0] meta_reg;   // first stage, read only by the second
    reg [NPINS-1:0] sync_reg;   // second stage, safe to use

    // double flop crossing of the asynchronous pins
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_reg <= {NPINS{1'b0}};
            sync_reg <= {NPINS{1'b0}};
        end else begin
            meta_reg <= pin_raw;
            sync_reg <= meta_reg;
        end
    end

    // active-low pins are inverted after the crossing
    assign pin_active = sync_reg ^ pol_low;

endmodule // rap_pin_sync

`default_nettype wire

// [design/rap_regs.vh]
`ifndef RAP_REGS_VH
`define RAP_REGS_VH

// register offsets (byte addresses)
`define RAP_ADDR_CTRL     8'h00
`define RAP_ADDR_POL      8'h04
`define RAP_ADDR_FUNC     8'h08
`define RAP_ADDR_STATE    8'h0C
`define RAP_ADDR_INT_STAT 8'h10
`define RAP_ADDR_INT_MASK 8'h14

// operating modes in ctrl[1:0]
`define RAP_MODE_ANALOG   2'h0
`define RAP_MODE_DIGITAL  2'h1
`define RAP_MODE_MIXED    2'h2

// pin function codes, four bits per pin in the function register
`define RAP_FN_NONE       4'h0
`define RAP_FN_TX_KEY     4'h1
`define RAP_FN_MONITOR    4'h2
`define RAP_FN_KNOCKDOWN  4'h3
`define RAP_FN_SQ_DET     4'h4
`define RAP_FN_TONE_DET   4'h5
`define RAP_FN_ANT_RELAY  4'h6

// state and interrupt bit positions
`define RAP_BIT_TX_KEY    0
`define RAP_BIT_MONITOR   1
`define RAP_BIT_KNOCKDOWN 2
`define RAP_BIT_SQ_DET    3
`define RAP_BIT_TONE_DET  4
`define RAP_BIT_RELAY     5
`define RAP_BIT_ALERT     6
`define RAP_NUM_EVENTS    7

// reset values
`define RAP_RST_CTRL      2'h0
`define RAP_RST_MASK      7'h00

`endif

// [design/rap_top.v]
`timescale 1ns/1ps
`default_nettype none
`include "rap_regs.vh"

// programmable accessory pin logic of a repeater rear connector
module rap_top #(
    parameter NPINS = 8
) (
    // clock and reset
    input  wire             clk,
    input  wire             resetn,
    // register port
    input  wire [7:0]       reg_addr,
    input  wire [31:0]      reg_wdata,
    input  wire             reg_wr,
    input  wire             reg_rd,
    output reg  [31:0]      reg_rdata,
    // interrupt
    output wire             irq,
    // accessory pins
    input  wire [NPINS-1:0] pin_in,
    output reg  [NPINS-1:0] pin_out,
    output reg  [NPINS-1:0] pin_oe,
    // radio core status, same clock
    input  wire             squelch_det,
    input  wire             tone_det,
    input  wire             digital_call_active,
    input  wire             station_id_tx,
    input  wire             channel_busy,
    input  wire             digital_activity,
    input  wire             rf_carrier,
    input  wire             qualified_rf,
    input  wire             digital_tx_active,
    input  wire             tx_state,
    // radio core controls
    output reg              busy_alert_tone,
    output reg              carrier_squelch_sel,
    output reg              rx_audio_enable,
    output reg              speaker_unmute,
    output reg              repeat_path_disabled,
    output reg              tx_key_request,
    output reg              tx_audio_from_pin
);

    localparam NEV = `RAP_NUM_EVENTS;

    // software-visible configuration and block state
    // the first six registers below sit in flip-flops and clear on reset,
    // so after reset no pin carries a function and all pins are active high;
    // nothing is driven onto the connector until software assigns an output
    // function to a pin, which keeps a freshly reset unit from fighting an
    // accessory that is already driving the same line.
    // status and mask share one layout with the state register, so a
    // single bit index names one condition everywhere
    reg  [1:0]         ctrl_reg;      // operating mode
    reg  [NPINS-1:0]   pol_reg;       // per pin polarity, 1 = active low
    reg  [4*NPINS-1:0] func_reg;      // per pin function code
    reg  [NEV-1:0]     int_stat_reg;  // sticky event bits
    reg  [NEV-1:0]     int_mask_reg;  // interrupt enables
    reg  [NEV-1:0]     state_reg;     // registered block state
    reg  [NEV-1:0]     int_stat_next;
    reg  [31:0]        rdata_next;
    reg  [NPINS-1:0]   out_next;
    reg  [NPINS-1:0]   oe_next;

    // decoded conditions, all on the single block clock
    // input functions are gathered from the synchronised pin levels only,
    // never from the raw pins, so each one sees a clean level change.
    // core status inputs come from logic on this clock and need no crossing.
    // output conditions are formed here and registered at the pin drivers,
    // which keeps the connector free of glitches from the decode.
    // several pins may share one input function; their levels are ORed
    // so either of two keying accessories can key the transmitter
    wire [NPINS-1:0]   pin_active;    // synchronised, polarity applied
    wire [NEV-1:0]     state_next;
    wire [NEV-1:0]     events;
    wire               mixed;
    wire               analog;
    wire               tx_key;
    wire               monitor;
    wire               knock;
    wire               knock_eff;
    wire               sq_out;
    wire               tone_out;
    wire               relay;
    wire               alert;
    wire               clr_wr;
    integer            i;

    // true when any pin of the given function is asserted
    function any_func;
        input [NPINS-1:0]   act;
        input [4*NPINS-1:0] fn;
        input [3:0]         code;
        integer k;
        begin
            any_func = 1'b0;
            for (k = 0; k < NPINS; k = k + 1) begin
                if (fn[4*k +: 4] == code && act[k])
                    any_func = 1'b1;
            end
        end
    endfunction

    // true when the pin carries an output function
    function is_out_fn;
        input [3:0] code;
        begin
            is_out_fn = (code == `RAP_FN_SQ_DET) || (code == `RAP_FN_TONE_DET) ||
                        (code == `RAP_FN_ANT_RELAY);
        end
    endfunction

    // input crossing and polarity
    rap_pin_sync #(
        .NPINS      (NPINS)
    ) u_sync (
        .clk        (clk),
        .resetn     (resetn),
        .pin_raw    (pin_in),
        .pol_low    (pol_reg),
        .pin_active (pin_active)
    );

    // mode decode
    assign mixed  = (ctrl_reg == `RAP_MODE_MIXED);
    assign analog = (ctrl_reg == `RAP_MODE_ANALOG);

    // input functions gathered from whichever pins carry them
    assign tx_key  = any_func(pin_active, func_reg, `RAP_FN_TX_KEY);
    assign monitor = any_func(pin_active, func_reg, `RAP_FN_MONITOR);
    assign knock   = any_func(pin_active, func_reg, `RAP_FN_KNOCKDOWN);

    // knockdown handling
    // a knockdown that arrives during a digital transmission in mixed mode
    // has no effect until that transmission ends; the raw knockdown level
    // is still tracked, so the mode is entered as soon as the core reports
    // the digital transmission over, with no need to re-assert the pin.
    // outside mixed mode the gate is open and the pin acts at once
    // knockdown is held off while a digital transmission runs in mixed mode
    assign knock_eff = knock & ~(mixed & digital_tx_active);

    // busy alert in mixed mode on keying into a busy channel or monitoring digital traffic
    assign alert = mixed & ((tx_key & channel_busy) |
                            (monitor & digital_activity));

    // squelch detect, widened in mixed mode
    assign sq_out = squelch_det |
                    (mixed & (digital_call_active | station_id_tx));

    // tone code detect, widened in mixed mode
    assign tone_out = tone_det |
                      (mixed & (digital_call_active | station_id_tx));

    // antenna relay only in analog mode
    assign relay = tx_state & analog;

    // state vector, also the event sources
    assign state_next[`RAP_BIT_TX_KEY]    = tx_key;
    assign state_next[`RAP_BIT_MONITOR]   = monitor;
    assign state_next[`RAP_BIT_KNOCKDOWN] = knock_eff;
    assign state_next[`RAP_BIT_SQ_DET]    = sq_out;
    assign state_next[`RAP_BIT_TONE_DET]  = tone_out;
    assign state_next[`RAP_BIT_RELAY]     = relay;
    assign state_next[`RAP_BIT_ALERT]     = alert;

    // event detection
    // both edges of every state bit raise its status bit, so software learns
    // of an accessory releasing a pin as well as asserting it.
    // the state register resets to all zero, matching an idle connector with
    // no functions assigned, so no false event follows reset.
    // a change of configuration that alters a decoded condition counts too
    // any change of a state bit is an event
    assign events = state_next ^ state_reg;

    // write-one-to-clear strobe for the status register
    assign clr_wr = reg_wr && (reg_addr == `RAP_ADDR_INT_STAT);

    // sticky status: a new event wins over a clear in the same cycle
    always @* begin
        int_stat_next = (int_stat_reg & ~(clr_wr ? reg_wdata[NEV-1:0] : {NEV{1'b0}}))
                        | events;
    end

    // level interrupt while an unmasked status bit is set
    assign irq = |(int_stat_reg & int_mask_reg);

    // output pin drive
    // only pins with an output function are enabled; input and unused pins
    // stay released so the accessory side owns them.
    // the polarity bit inverts the logical level on the way out, so an
    // active-low output idles high while its condition is false.
    // an unknown code on an enabled pin falls back to the inactive level
    // pin output drive from function and polarity
    always @* begin
        out_next = {NPINS{1'b0}};
        oe_next  = {NPINS{1'b0}};
        for (i = 0; i < NPINS; i = i + 1) begin
            if (is_out_fn(func_reg[4*i +: 4])) begin
                oe_next[i] = 1'b1;
                case (func_reg[4*i +: 4])
                    `RAP_FN_SQ_DET:    out_next[i] = sq_out ^ pol_reg[i];
                    `RAP_FN_TONE_DET:  out_next[i] = tone_out ^ pol_reg[i];
                    `RAP_FN_ANT_RELAY: out_next[i] = relay ^ pol_reg[i];
                    default:           out_next[i] = pol_reg[i];
                endcase
            end
        end
    end

    // read data mux, zero for unmapped addresses
    always @* begin
        rdata_next = 32'h0000_0000;
        case (reg_addr)
            `RAP_ADDR_CTRL: begin
                rdata_next[1:0] = ctrl_reg;
            end
            `RAP_ADDR_POL: begin
                rdata_next[NPINS-1:0] = pol_reg;
            end
            `RAP_ADDR_FUNC: begin
                rdata_next[4*NPINS-1:0] = func_reg;
            end
            `RAP_ADDR_STATE: begin
                rdata_next[NEV-1:0]       = state_reg;
                rdata_next[8 +: NPINS]    = pin_active;
            end
            `RAP_ADDR_INT_STAT: begin
                rdata_next[NEV-1:0] = int_stat_reg;
            end
            `RAP_ADDR_INT_MASK: begin
                rdata_next[NEV-1:0] = int_mask_reg;
            end
            default: begin
                rdata_next = 32'h0000_0000;
            end
        endcase
    end

    // register writes
    // a write takes effect at the edge that samples the strobe, so a read
    // issued right after it already returns the new value.
    // writes to the read-only state register or to unmapped offsets are
    // dropped without effect; the status register is cleared elsewhere,
    // where the set-wins rule against new events is applied.
    // changing a function code moves a role between pins at once; software
    // should set polarity first so a new output does not glitch active
    // configuration registers written by software
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_reg     <= `RAP_RST_CTRL;
            pol_reg      <= {NPINS{1'b0}};
            func_reg     <= {4*NPINS{1'b0}};
            int_mask_reg <= `RAP_RST_MASK;
        end else if (reg_wr) begin
            case (reg_addr)
                `RAP_ADDR_CTRL: begin
                    ctrl_reg <= reg_wdata[1:0];
                end
                `RAP_ADDR_POL: begin
                    pol_reg <= reg_wdata[NPINS-1:0];
                end
                `RAP_ADDR_FUNC: begin
                    func_reg <= reg_wdata[4*NPINS-1:0];
                end
                `RAP_ADDR_INT_MASK: begin
                    int_mask_reg <= reg_wdata[NEV-1:0];
                end
                default: begin
                    ctrl_reg <= ctrl_reg;
                end
            endcase
        end
    end

    // read data stands in the cycle after the read strobe only
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            reg_rdata <= rdata_next;
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // state and sticky status
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg    <= {NEV{1'b0}};
            int_stat_reg <= {NEV{1'b0}};
        end else begin
            state_reg    <= state_next;
            int_stat_reg <= int_stat_next;
        end
    end

    // accessory pin drivers
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_out <= {NPINS{1'b0}};
            pin_oe  <= {NPINS{1'b0}};
        end else begin
            pin_out <= out_next;
            pin_oe  <= oe_next;
        end
    end

    // radio core controls
    // all controls are registered, one edge after the decoded condition,
    // so a pin change reaches the core three edges after it appears.
    // the receive audio line and the speaker share one unmute condition;
    // they never differ, since both follow the same monitor decision.
    // in knockdown the repeat path cannot key the transmitter, but the
    // external key still does, and transmit audio is taken from the pin.
    // on release the qualified carrier keys again with no extra delay.
    // the alert tone is a level for as long as its cause stands; the core
    // decides how the tone itself is shaped on the speaker and audio lines
    // controls toward the radio core
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busy_alert_tone      <= 1'b0;
            carrier_squelch_sel  <= 1'b0;
            rx_audio_enable      <= 1'b0;
            speaker_unmute       <= 1'b0;
            repeat_path_disabled <= 1'b0;
            tx_key_request       <= 1'b0;
            tx_audio_from_pin    <= 1'b0;
        end else begin
            busy_alert_tone     <= alert;
            carrier_squelch_sel <= monitor;
            // digital traffic in mixed mode never unmutes the audio
            rx_audio_enable     <= monitor & rf_carrier &
                                   ~(mixed & digital_activity);
            speaker_unmute      <= monitor & rf_carrier &
                                   ~(mixed & digital_activity);
            repeat_path_disabled <= knock_eff;
            // in knockdown only the external key may key the transmitter
            tx_key_request      <= tx_key | (~knock_eff & qualified_rf);
            tx_audio_from_pin   <= knock_eff;
        end
    end

endmodule // rap_top

`default_nettype wire

// [sim/rap_acc_model.sv]
`timescale 1ns/1ps
`default_nettype none

// accessory on the rear connector: drives input pins, reads output pins
module rap_acc_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // commanded levels: key pin0, monitor pin1, knockdown pin2, key pin6
    input  wire logic [3:0] acc_cmd,
    input  wire logic [7:0] pol,
    // block side of the pins
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    output logic      [7:0] pin_in,
    // decoded output functions
    output logic            sq_lvl,
    output logic            tone_lvl,
    output logic            relay_lvl
);
    logic       spare;  // unused pin: level changes every cycle
    logic [7:0] drv;    // accessory drive; output pins pulled up

    // toggling pattern so the unused pin never settles
    always @(posedge clk or negedge resetn) begin
        if (!resetn) spare <= 1'b0;
        else spare <= ~spare;
    end

    // commanded level goes out through the pin polarity
    assign drv = ({spare, acc_cmd[3], 3'h0, acc_cmd[2:0]} ^ pol) | 8'h38;
    // wire level: block wins where it drives
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & drv);
    // outputs read back through polarity
    assign sq_lvl = pin_oe[3] & (pin_out[3] ^ pol[3]);
    assign tone_lvl = pin_oe[4] & (pin_out[4] ^ pol[4]);
    assign relay_lvl = pin_oe[5] & (pin_out[5] ^ pol[5]);
endmodule // rap_acc_model

`default_nettype wire

// [sim/rap_top_chk.sv]
`timescale 1ns/1ps
`default_nettype none

// port-level checks on the accessory pin block
module rap_top_chk (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // register port
    input  wire logic        reg_rd,
    input  wire logic [31:0] reg_rdata,
    // core status and controls
    input  wire logic        rf_carrier,
    input  wire logic        qualified_rf,
    input  wire logic        channel_busy,
    input  wire logic        digital_activity,
    input  wire logic        busy_alert_tone,
    input  wire logic        carrier_squelch_sel,
    input  wire logic        rx_audio_enable,
    input  wire logic        speaker_unmute,
    input  wire logic        repeat_path_disabled,
    input  wire logic        tx_key_request,
    input  wire logic        tx_audio_from_pin
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // read strobe followed by a quiet cycle
    sequence s_read_then_idle;
        reg_rd ##1 !reg_rd;
    endsequence

    // alert heard while digital activity is on the channel
    sequence s_digital_alert;
        busy_alert_tone && $past(digital_activity);
    endsequence

    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data not zero outside read cycle");
    a_rdata_stands: assert property (s_read_then_idle |=> reg_rdata == 32'h0)
        else $error("read data held longer than one cycle");
    a_unmute_pair: assert property (speaker_unmute == rx_audio_enable)
        else $error("speaker and rx audio disagree");
    a_unmute_cause: assert property (speaker_unmute |-> carrier_squelch_sel && $past(rf_carrier))
        else $error("unmute without monitor and carrier");
    a_digital_muted: assert property (s_digital_alert |-> !speaker_unmute)
        else $error("digital activity unmuted");
    a_alert_cause: assert property (busy_alert_tone |-> $past(channel_busy || digital_activity))
        else $error("alert tone without busy channel");
    a_audio_kd: assert property (tx_audio_from_pin == repeat_path_disabled)
        else $error("audio source disagrees with repeat path");
    a_rf_keys: assert property (!repeat_path_disabled && $past(qualified_rf) |-> tx_key_request)
        else $error("qualified carrier did not key in normal mode");
endmodule // rap_top_chk

bind rap_top rap_top_chk u_chk (.clk, .resetn, .reg_rd, .reg_rdata, .rf_carrier, .qualified_rf,
    .channel_busy, .digital_activity, .busy_alert_tone, .carrier_squelch_sel, .rx_audio_enable,
    .speaker_unmute, .repeat_path_disabled, .tx_key_request, .tx_audio_from_pin);

`default_nettype wire

// [sim/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "rap_regs.vh"

// register-driven tests of the accessory pin block
module testbench;
    logic        clk, resetn, reg_wr, reg_rd, irq, sq_lvl, tone_lvl, relay_lvl;
    logic [7:0]  reg_addr, pin_in, pin_out, pin_oe;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic [9:0]  core;  // sq,tone,dcall,id,busy,dact,carrier,qrf,dtx,txst
    logic [3:0]  acc;   // accessory commands
    logic        busy_alert_tone, carrier_squelch_sel, rx_audio_enable, speaker_unmute;
    logic        repeat_path_disabled, tx_key_request, tx_audio_from_pin;
    int          n_fail, comparisons;

    rap_top u_dut (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
        .pin_in, .pin_out, .pin_oe, .squelch_det(core[9]), .tone_det(core[8]),
        .digital_call_active(core[7]), .station_id_tx(core[6]), .channel_busy(core[5]),
        .digital_activity(core[4]), .rf_carrier(core[3]), .qualified_rf(core[2]),
        .digital_tx_active(core[1]), .tx_state(core[0]), .busy_alert_tone, .carrier_squelch_sel,
        .rx_audio_enable, .speaker_unmute, .repeat_path_disabled, .tx_key_request,
        .tx_audio_from_pin);
    rap_acc_model u_acc (.clk, .resetn, .acc_cmd(acc), .pol(8'h48), .pin_out, .pin_oe,
        .pin_in, .sq_lvl, .tone_lvl, .relay_lvl);

    // clock of 100 ns
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // comparison of one level
    task chk_bit(input logic g, input logic e);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %0t level %b expected %b", $time, g, e);
        end
    endtask
    // comparison of one word
    task chk_word(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %0t word %h expected %h", $time, g, e);
        end
    endtask
    // one-cycle write; effect visible on return
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    // one-cycle read, masked compare of the answer
    task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        chk_word(d & m, e);
    endtask
    // new core and accessory levels, then let pins sync through
    task setc(input logic [9:0] v, input logic [3:0] a);
        @(posedge clk);
        core <= v; acc <= a;
        repeat (4) @(posedge clk);
        #1;
    endtask
    // squelch and tone outputs for one core state
    task sqt(input logic [9:0] v, input logic es, input logic et);
        setc(v, 4'h0);
        chk_bit(sq_lvl, es);
        chk_bit(tone_lvl, et);
    endtask

    // verdict and end of run
    task complete_run;
        $display("mismatches %0d comparisons %0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // hang guard
    initial begin
        repeat (3000) @(posedge clk);
        n_fail++;
        complete_run;
    end

    // main sequence
    initial begin
        n_fail = 0; comparisons = 0; resetn = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0;
        reg_addr = 8'h00; reg_wdata = 32'h0; core = 10'h000; acc = 4'h0;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        chk_word({24'h0, pin_oe}, 32'h0);
        rdc(`RAP_ADDR_CTRL, 32'hFFFFFFFF, 32'h0);
        rdc(`RAP_ADDR_FUNC, 32'hFFFFFFFF, 32'h0);
        rdc(8'h18, 32'hFFFFFFFF, 32'h0);
        // pins: key0 monitor1 knockdown2 sq3 tone4 relay5 key6; pins 3 and 6 active low
        wr(`RAP_ADDR_POL, 32'h48);
        wr(`RAP_ADDR_FUNC, 32'h01654321);
        rdc(`RAP_ADDR_FUNC, 32'hFFFFFFFF, 32'h01654321);
        setc(10'h000, 4'h0);
        chk_word({24'h0, pin_oe}, 32'h38);
        chk_bit(pin_out[3], 1'b1);
        // interrupt on the key bit
        wr(`RAP_ADDR_INT_MASK, 32'h01);
        wr(`RAP_ADDR_INT_STAT, 32'h7F);
        chk_bit(irq, 1'b0);
        setc(10'h000, 4'h1);
        chk_bit(tx_key_request, 1'b1);
        chk_bit(irq, 1'b1);
        rdc(`RAP_ADDR_STATE, 32'h1, 32'h1);
        wr(`RAP_ADDR_INT_STAT, 32'h01);
        chk_bit(irq, 1'b0);
        setc(10'h000, 4'h0);
        chk_bit(irq, 1'b1);
        wr(`RAP_ADDR_INT_STAT, 32'h01);
        wr(`RAP_ADDR_INT_MASK, 32'h00);
        chk_bit(irq, 1'b0);
        setc(10'h000, 4'h8);
        chk_bit(tx_key_request, 1'b1);
        setc(10'h000, 4'h0);
        chk_bit(tx_key_request, 1'b0);
        // monitor, analog then mixed
        setc(10'h008, 4'h2);
        chk_bit(carrier_squelch_sel, 1'b1);
        chk_bit(speaker_unmute, 1'b1);
        wr(`RAP_ADDR_CTRL, 32'h2);
        setc(10'h018, 4'h2);
        chk_bit(rx_audio_enable, 1'b0);
        chk_bit(busy_alert_tone, 1'b1);
        setc(10'h008, 4'h2);
        chk_bit(rx_audio_enable, 1'b1);
        // key while busy: alert only in mixed mode
        setc(10'h020, 4'h1);
        chk_bit(busy_alert_tone, 1'b1);
        wr(`RAP_ADDR_CTRL, 32'h0);
        setc(10'h020, 4'h1);
        chk_bit(busy_alert_tone, 1'b0);
        // detect outputs, analog then mixed
        sqt(10'h200, 1'b1, 1'b0);
        chk_bit(pin_out[3], 1'b0);
        sqt(10'h100, 1'b0, 1'b1);
        sqt(10'h0C0, 1'b0, 1'b0);
        wr(`RAP_ADDR_CTRL, 32'h2);
        sqt(10'h080, 1'b1, 1'b1);
        sqt(10'h040, 1'b1, 1'b1);
        sqt(10'h000, 1'b0, 1'b0);
        // knockdown
        wr(`RAP_ADDR_CTRL, 32'h0);
        setc(10'h004, 4'h4);
        chk_bit(repeat_path_disabled, 1'b1);
        chk_bit(tx_audio_from_pin, 1'b1);
        chk_bit(tx_key_request, 1'b0);
        setc(10'h004, 4'h5);
        chk_bit(tx_key_request, 1'b1);
        setc(10'h004, 4'h0);
        chk_bit(tx_key_request, 1'b1);
        wr(`RAP_ADDR_CTRL, 32'h2);
        setc(10'h002, 4'h4);
        chk_bit(repeat_path_disabled, 1'b0);
        setc(10'h000, 4'h4);
        chk_bit(repeat_path_disabled, 1'b1);
        // relay in each mode
        for (int m = 0; m < 3; m++) begin
            wr(`RAP_ADDR_CTRL, m);
            setc(10'h001, 4'h0);
            chk_bit(relay_lvl, m == 0);
            setc(10'h000, 4'h0);
            chk_bit(relay_lvl, 1'b0);
        end
        complete_run;
    end
endmodule // testbench

`default_nettype wire
